// [verilog/pb_out_pkg.sv]
// package: register map, field layout and reset values of the playback output register bank
package pb_out_pkg;

    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [15:0] ADDR_LMIX  = 16'h4020;
    localparam logic [15:0] ADDR_RMIX  = 16'h4021;
    localparam logic [15:0] ADDR_MMIX  = 16'h4022;
    localparam logic [15:0] ADDR_LHP   = 16'h4023;
    localparam logic [15:0] ADDR_RHP   = 16'h4024;
    localparam logic [15:0] ADDR_LLINE = 16'h4025;
    localparam logic [15:0] ADDR_RLINE = 16'h4026;
    localparam logic [15:0] ADDR_MONO  = 16'h4027;

    // ----------------------------------------
    // field positions and codes
    // ----------------------------------------
    localparam int          POS_BOOST_HI = 3;
    localparam int          POS_BOOST_LO = 1;
    localparam int          POS_LEVEL    = 2;
    localparam int          POS_UNMUTE   = 1;
    localparam int          POS_BIT0     = 0;
    localparam logic [1:0]  BOOST_MUTE   = 2'h0;
    localparam logic [1:0]  BOOST_RSVD   = 2'h3;
    localparam logic [1:0]  MONO_COMMON  = 2'h0;
    localparam logic [5:0]  LEVEL_0DB    = 6'h39;
    localparam logic [5:0]  LEVEL_NONE   = 6'h00;

    // ----------------------------------------
    // reset values and writable masks
    // ----------------------------------------
    localparam logic [7:0]  RST_MIX      = 8'h00;
    localparam logic [7:0]  RST_DRV      = 8'h02;
    localparam logic [7:0]  MASK_LRMIX   = 8'h1F;
    localparam logic [7:0]  MASK_MMIX    = 8'h07;
    localparam logic [7:0]  MASK_DRV     = 8'hFF;

    typedef struct packed {
        logic [5:0] level;
        logic       unmute;
        logic       pin_mode;
    } drv_ctl_s;

    typedef struct packed {
        logic [1:0] right_pb_boost;
        logic [1:0] left_pb_boost;
        logic       enable;
    } line_mix_s;

endpackage : pb_out_pkg

// [verilog/playback_output_mix_volume_regs.sv]
// module: playback output mixer and driver control register bank
`timescale 1ns/10ps

// Operation
// - left mixer right-input boost code, reset mute
// - left mixer left-input boost code, reset mute
// - bit0 mixer enables, reset disabled
// - right mixer right-input boost code, reset mute
// - right mixer left-input boost code, reset mute
// - mono mixer code, reset common-mode
// - six-bit levels in bits 7:2, reset zero
// - left phones level, unmute, global enable
// - right phones level and unmute
// - right phones bit0 selects phones pin mode
// - left line level, unmute, reset unmuted
// - right line level, unmute, reset unmuted
// - line bit0 selects line or phones mode
// - mono level, unmute, mode fields
// - common-mode mono ignores level field
// - left line mixer at address 0x4020
module playback_output_mix_volume_regs (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic                     wr_en,
    input  wire logic                     rd_en,
    input  wire logic [15:0]              addr,
    input  wire logic [7:0]               wr_data,
    output logic      [7:0]               rd_data,
    output logic                          rd_valid,
    output pb_out_pkg::line_mix_s         lmix_out,
    output pb_out_pkg::line_mix_s         rmix_out,
    output logic      [1:0]               mono_mix_code,
    output logic                          mono_mix_enable,
    output pb_out_pkg::drv_ctl_s          left_phones_out,
    output pb_out_pkg::drv_ctl_s          right_phones_out,
    output pb_out_pkg::drv_ctl_s          left_line_out,
    output pb_out_pkg::drv_ctl_s          right_line_out,
    output pb_out_pkg::drv_ctl_s          mono_out,
    output logic                          phones_driver_enable,
    output logic                          mono_common_mode
);

    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [7:0] lmix_ff;
    logic [7:0] rmix_ff;
    logic [7:0] mmix_ff;
    logic [7:0] lhp_ff;
    logic [7:0] rhp_ff;
    logic [7:0] lline_ff;
    logic [7:0] rline_ff;
    logic [7:0] mono_ff;
    logic [7:0] nxt_rd_data;

    // reserved boost code is applied as mute
    function automatic logic [1:0] eff_boost(input logic [1:0] code);
        eff_boost = (code == pb_out_pkg::BOOST_RSVD) ? pb_out_pkg::BOOST_MUTE : code;
    endfunction : eff_boost

    function automatic pb_out_pkg::drv_ctl_s drv_fields(input logic [7:0] r);
        drv_fields.level    = r[7:pb_out_pkg::POS_LEVEL];
        drv_fields.unmute   = r[pb_out_pkg::POS_UNMUTE];
        drv_fields.pin_mode = r[pb_out_pkg::POS_BIT0];
    endfunction : drv_fields

    function automatic pb_out_pkg::line_mix_s mix_fields(input logic [7:0] r);
        mix_fields.right_pb_boost = eff_boost(r[4:pb_out_pkg::POS_BOOST_HI]);
        mix_fields.left_pb_boost  = eff_boost(r[2:pb_out_pkg::POS_BOOST_LO]);
        mix_fields.enable         = r[pb_out_pkg::POS_BIT0];
    endfunction : mix_fields

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lmix_ff  <= pb_out_pkg::RST_MIX;
            rmix_ff  <= pb_out_pkg::RST_MIX;
            mmix_ff  <= pb_out_pkg::RST_MIX;
            lhp_ff   <= pb_out_pkg::RST_DRV;
            rhp_ff   <= pb_out_pkg::RST_DRV;
            lline_ff <= pb_out_pkg::RST_DRV;
            rline_ff <= pb_out_pkg::RST_DRV;
            mono_ff  <= pb_out_pkg::RST_DRV;
        end else if (wr_en) begin
            case (addr)
                pb_out_pkg::ADDR_LMIX:  lmix_ff  <= wr_data & pb_out_pkg::MASK_LRMIX;
                pb_out_pkg::ADDR_RMIX:  rmix_ff  <= wr_data & pb_out_pkg::MASK_LRMIX;
                pb_out_pkg::ADDR_MMIX:  mmix_ff  <= wr_data & pb_out_pkg::MASK_MMIX;
                pb_out_pkg::ADDR_LHP:   lhp_ff   <= wr_data & pb_out_pkg::MASK_DRV;
                pb_out_pkg::ADDR_RHP:   rhp_ff   <= wr_data & pb_out_pkg::MASK_DRV;
                pb_out_pkg::ADDR_LLINE: lline_ff <= wr_data & pb_out_pkg::MASK_DRV;
                pb_out_pkg::ADDR_RLINE: rline_ff <= wr_data & pb_out_pkg::MASK_DRV;
                pb_out_pkg::ADDR_MONO:  mono_ff  <= wr_data & pb_out_pkg::MASK_DRV;
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    always_comb begin
        case (addr)
            pb_out_pkg::ADDR_LMIX:  nxt_rd_data = lmix_ff;
            pb_out_pkg::ADDR_RMIX:  nxt_rd_data = rmix_ff;
            pb_out_pkg::ADDR_MMIX:  nxt_rd_data = mmix_ff;
            pb_out_pkg::ADDR_LHP:   nxt_rd_data = lhp_ff;
            pb_out_pkg::ADDR_RHP:   nxt_rd_data = rhp_ff;
            pb_out_pkg::ADDR_LLINE: nxt_rd_data = lline_ff;
            pb_out_pkg::ADDR_RLINE: nxt_rd_data = rline_ff;
            pb_out_pkg::ADDR_MONO:  nxt_rd_data = mono_ff;
            default:                nxt_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            rd_data  <= rd_en ? nxt_rd_data : 8'h00;
        end
    end

    // ----------------------------------------
    // field outputs to the analog stage
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lmix_out             <= '0;
            rmix_out             <= '0;
            mono_mix_code        <= pb_out_pkg::MONO_COMMON;
            mono_mix_enable      <= 1'b0;
            left_phones_out      <= drv_fields(pb_out_pkg::RST_DRV);
            right_phones_out     <= drv_fields(pb_out_pkg::RST_DRV);
            left_line_out        <= drv_fields(pb_out_pkg::RST_DRV);
            right_line_out       <= drv_fields(pb_out_pkg::RST_DRV);
            mono_out             <= {pb_out_pkg::LEVEL_0DB, pb_out_pkg::RST_DRV[1:0]};
            phones_driver_enable <= 1'b0;
            mono_common_mode     <= 1'b1;
        end else begin
            lmix_out             <= mix_fields(lmix_ff);
            rmix_out             <= mix_fields(rmix_ff);
            mono_mix_code        <= eff_boost(mmix_ff[2:pb_out_pkg::POS_BOOST_LO]);
            mono_mix_enable      <= mmix_ff[pb_out_pkg::POS_BIT0];
            left_phones_out      <= drv_fields({lhp_ff[7:1], rhp_ff[0]});
            right_phones_out     <= drv_fields(rhp_ff);
            left_line_out        <= drv_fields(lline_ff);
            right_line_out       <= drv_fields(rline_ff);
            phones_driver_enable <= lhp_ff[pb_out_pkg::POS_BIT0];
            mono_common_mode     <= (mmix_ff[2:1] == pb_out_pkg::MONO_COMMON);
            if (mmix_ff[2:1] == pb_out_pkg::MONO_COMMON) begin
                mono_out <= {pb_out_pkg::LEVEL_0DB, mono_ff[1:0]};
            end else begin
                mono_out <= drv_fields(mono_ff);
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_lmix_write: assert property (@(posedge core_clk) disable iff (rst)
        wr_en && addr == pb_out_pkg::ADDR_LMIX ##1 !wr_en |=> lmix_out.enable == $past(wr_data[0], 2))
        else $error("left mixer enable not applied");
    a_reserved_mute: assert property (@(posedge core_clk) disable iff (rst)
        wr_en && addr == pb_out_pkg::ADDR_RMIX && wr_data[4:3] == 2'h3 ##1 !wr_en
        |=> rmix_out.right_pb_boost == 2'h0)
        else $error("reserved boost not muted");
    a_reserved_read: assert property (@(posedge core_clk) disable iff (rst)
        rd_en && addr == pb_out_pkg::ADDR_LMIX |=> rd_data[7:5] == 3'h0)
        else $error("reserved bits read nonzero");
    a_mono_common: assert property (@(posedge core_clk) disable iff (rst)
        mono_common_mode |-> mono_out.level == pb_out_pkg::LEVEL_0DB)
        else $error("common-mode mono has level applied");
    a_mono_level: assert property (@(posedge core_clk) disable iff (rst)
        $stable(mono_ff) && $stable(mmix_ff) && mmix_ff[2:1] != 2'h0
        |=> mono_out.level == $past(mono_ff[7:2]))
        else $error("mono level wrong");
    a_phones_mode: assert property (@(posedge core_clk) disable iff (rst)
        wr_en && addr == pb_out_pkg::ADDR_RHP ##1 !wr_en
        |=> left_phones_out.pin_mode == right_phones_out.pin_mode)
        else $error("phones pin modes differ");
    a_phones_enable: assert property (@(posedge core_clk) disable iff (rst)
        wr_en && addr == pb_out_pkg::ADDR_LHP ##1 !wr_en |=> phones_driver_enable == $past(wr_data[0], 2))
        else $error("phones enable not applied");
    a_line_read: assert property (@(posedge core_clk) disable iff (rst)
        wr_en && addr == pb_out_pkg::ADDR_LLINE ##1 rd_en && !wr_en && addr == pb_out_pkg::ADDR_LLINE
        |=> rd_data == $past(wr_data, 2))
        else $error("line register readback wrong");
    a_unmapped_read: assert property (@(posedge core_clk) disable iff (rst)
        rd_en && (addr < pb_out_pkg::ADDR_LMIX || addr > pb_out_pkg::ADDR_MONO) |=> rd_data == 8'h00)
        else $error("unmapped read nonzero");
    a_rd_valid_pulse: assert property (@(posedge core_clk) disable iff (rst)
        rd_valid == $past(rd_en))
        else $error("read valid not one cycle after strobe");
    a_rmix_enable: assert property (@(posedge core_clk) disable iff (rst)
        wr_en && addr == pb_out_pkg::ADDR_RMIX ##1 !wr_en |=> rmix_out.enable == $past(wr_data[0], 2))
        else $error("right mixer enable not applied");
    a_mmix_enable: assert property (@(posedge core_clk) disable iff (rst)
        wr_en && addr == pb_out_pkg::ADDR_MMIX ##1 !wr_en |=> mono_mix_enable == $past(wr_data[0], 2))
        else $error("mono mixer enable not applied");
    a_lphones_level: assert property (@(posedge core_clk) disable iff (rst)
        wr_en && addr == pb_out_pkg::ADDR_LHP ##1 !wr_en |=> left_phones_out.level == $past(wr_data[7:2], 2))
        else $error("left phones level not applied");
    a_rphones_field: assert property (@(posedge core_clk) disable iff (rst)
        wr_en && addr == pb_out_pkg::ADDR_RHP ##1 !wr_en |=> right_phones_out == $past(wr_data, 2))
        else $error("right phones fields not applied");
    a_lline_field: assert property (@(posedge core_clk) disable iff (rst)
        wr_en && addr == pb_out_pkg::ADDR_LLINE ##1 !wr_en |=> left_line_out == $past(wr_data, 2))
        else $error("left line fields not applied");
    a_rline_field: assert property (@(posedge core_clk) disable iff (rst)
        wr_en && addr == pb_out_pkg::ADDR_RLINE ##1 !wr_en |=> right_line_out == $past(wr_data, 2))
        else $error("right line fields not applied");

    c_mono_common: cover property (@(posedge core_clk) disable iff (rst) mono_common_mode && mono_out.pin_mode);
    c_line_phones: cover property (@(posedge core_clk) disable iff (rst) left_line_out.pin_mode);
    c_boost_six:   cover property (@(posedge core_clk) disable iff (rst) lmix_out.right_pb_boost == 2'h2);
    c_mono_level:  cover property (@(posedge core_clk) disable iff (rst) !mono_common_mode && mono_out.level != 6'h39);

endmodule : playback_output_mix_volume_regs

// [test/test_playback_output_mix_volume_regs.sv]
// testbench: register access, field outputs and reset of the playback output register bank
`timescale 1ns/10ps
module test_playback_output_mix_volume_regs;
    localparam logic [15:0] BASE = pb_out_pkg::ADDR_LMIX;
    logic                   core_clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   wr_en = 1'b0;
    logic                   rd_en = 1'b0;
    logic [15:0]            addr = 16'h0000;
    logic [7:0]             wr_data = 8'h00;
    logic [7:0]             rd_data;
    logic                   rd_valid;
    pb_out_pkg::line_mix_s  lmix_out;
    pb_out_pkg::line_mix_s  rmix_out;
    logic [1:0]             mono_mix_code;
    logic                   mono_mix_enable;
    pb_out_pkg::drv_ctl_s   left_phones_out;
    pb_out_pkg::drv_ctl_s   right_phones_out;
    pb_out_pkg::drv_ctl_s   left_line_out;
    pb_out_pkg::drv_ctl_s   right_line_out;
    pb_out_pkg::drv_ctl_s   mono_out;
    logic                   phones_driver_enable;
    logic                   mono_common_mode;
    logic [7:0]             expq[$];
    logic [7:0]             regv[8];
    int                     miscompares = 0;
    int                     comparisons = 0;

    playback_output_mix_volume_regs u_playback_output_mix_volume_regs (
        .core_clk, .rst, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .rd_valid, .lmix_out, .rmix_out,
        .mono_mix_code, .mono_mix_enable, .left_phones_out, .right_phones_out, .left_line_out,
        .right_line_out, .mono_out, .phones_driver_enable, .mono_common_mode);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial begin
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [7:0] msk(input int i);
        return (i < 2) ? pb_out_pkg::MASK_LRMIX : (i == 2) ? pb_out_pkg::MASK_MMIX : pb_out_pkg::MASK_DRV;
    endfunction : msk

    function automatic logic [1:0] eff(input logic [1:0] c);
        return (c == pb_out_pkg::BOOST_RSVD) ? pb_out_pkg::BOOST_MUTE : c;
    endfunction : eff

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic op(input logic we, input logic re, input logic [15:0] a, input logic [7:0] d);
        wr_en = we;
        rd_en = re;
        addr = a;
        wr_data = d;
        if (re) expq.push_back((a[15:3] == BASE[15:3]) ? regv[a[2:0]] : 8'h00);
        if (we && a[15:3] == BASE[15:3]) regv[a[2:0]] = d & msk(a[2:0]);
        @(posedge core_clk);
        #1;
    endtask : op

    task automatic settle();
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic read_all(input string name);
        for (int i = 0; i < 10; i++) op(1'b0, 1'b1, BASE + 16'(i), 8'h00);
        settle();
        $display("test %s done", name);
    endtask : read_all

    task automatic wrap_up();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    // read results taken off the queue as they appear
    always @(negedge core_clk) begin
        if (rd_valid === 1'b1) begin
            if (expq.size() > 0) chk(rd_data, expq.pop_front());
            else chk(rd_data, 8'hXX);
        end
    end

    initial begin
        #200000;
        miscompares++;
        wrap_up();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        logic [1:0] c;
        logic [7:0] v;
        void'($urandom(32'hEAE2));
        for (int i = 0; i < 8; i++) regv[i] = (i < 3) ? pb_out_pkg::RST_MIX : pb_out_pkg::RST_DRV;
        repeat (6) @(posedge core_clk);
        #1;
        rst = 1'b0;
        chk({7'h00, mono_common_mode}, 8'h01);
        chk({2'h0, mono_out.level}, {2'h0, pb_out_pkg::LEVEL_0DB});
        chk({7'h00, phones_driver_enable}, 8'h00);
        chk({3'h0, lmix_out}, 8'h00);
        chk(left_line_out, pb_out_pkg::RST_DRV);
        read_all("reset values");
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 10; i++) op(1'b1, 1'b0, BASE + 16'(i), 8'($urandom));
            op(1'b1, 1'b1, pb_out_pkg::ADDR_MONO, 8'($urandom));
            read_all("random readback");
        end
        for (int k = 0; k < 4; k++) begin
            c = 2'(k);
            v = 8'($urandom);
            op(1'b1, 1'b0, pb_out_pkg::ADDR_LMIX, {3'h0, c, c, 1'b1});
            op(1'b1, 1'b0, pb_out_pkg::ADDR_RMIX, {3'h0, c, ~c, c[0]});
            op(1'b1, 1'b0, pb_out_pkg::ADDR_MMIX, {5'h00, c, c[1]});
            op(1'b1, 1'b0, pb_out_pkg::ADDR_MONO, {v[7:1], c == 2'h0});
            settle();
            chk({3'h0, lmix_out}, {3'h0, eff(c), eff(c), 1'b1});
            chk({3'h0, rmix_out}, {3'h0, eff(c), eff(~c), c[0]});
            chk({5'h00, mono_mix_code, mono_mix_enable}, {5'h00, eff(c), c[1]});
            chk({7'h00, mono_common_mode}, {7'h00, c == 2'h0});
            chk(mono_out, (c == 2'h0) ? {pb_out_pkg::LEVEL_0DB, regv[7][1:0]} : regv[7]);
        end
        $display("test mixer codes done");
        for (int k = 0; k < 4; k++) begin
            for (int i = 3; i < 7; i++) op(1'b1, 1'b0, BASE + 16'(i), 8'($urandom));
            settle();
            chk(left_phones_out, {regv[3][7:1], regv[4][0]});
            chk({7'h00, phones_driver_enable}, {7'h00, regv[3][0]});
            chk(right_phones_out, regv[4]);
            chk(left_line_out, regv[5]);
            chk(right_line_out, regv[6]);
        end
        $display("test driver fields done");
        rst = 1'b1;
        @(posedge core_clk);
        #1;
        rst = 1'b0;
        for (int i = 0; i < 8; i++) regv[i] = (i < 3) ? pb_out_pkg::RST_MIX : pb_out_pkg::RST_DRV;
        chk(right_phones_out, pb_out_pkg::RST_DRV);
        read_all("second reset");
        chk(8'(expq.size()), 8'h00);
        wrap_up();
    end
endmodule : test_playback_output_mix_volume_regs
